/* File: rtl/wdt_map.svh */
// Register offsets, field positions, reset values and timing counts of the watchdog unit.
// How it works
// - A free-running 6-bit counter is stepped through a 12-bit prescaler on the crystal clock.
// - Unserviced, overflow resets after 2^13-2^4 or 2^18-2^4 cycles, chosen by long_timeout_select.
// - Any write to the service port clears counter and prescaler stages 12 to 5 (bits 11 to 4).
// - Reading the service port returns the reset vector low byte, not watchdog state.
// - Overflow drives the reset pin low 32 cycles and sets the watchdog cause flag.
// - The stop instruction clears the prescaler.
// - Power-on logic clears the prescaler 4096 crystal cycles after power-up.
// - Any internal reset clears prescaler and counter.
// - A reset vector fetch clears the prescaler.
// - The watchdog_disable input, following its configuration bit, disables the watchdog.
// - In monitor mode high test voltage on interrupt or reset pin disables it.
// - In break state high test voltage on the reset pin disables it.
// - The watchdog keeps counting during wait mode.
// - The watchdog raises no processor interrupt; its only action is system reset.
// - The watchdog clock is the crystal clock itself.
// - In stop mode counting stops and the prescaler is held clear.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_SERVICE_INDEX  32'h0000ffff
`define WDT_SERVICE_ADDR   (`WDT_SERVICE_INDEX * 4)
`define WDT_CONFIG_ADDR    32'h00000000
`define WDT_CAUSE_ADDR     32'h00000004
`define WDT_CLEAR_ADDR     32'h00000008
`define WDT_ENABLE_ADDR    32'h0000000c
`define WDT_COUNT_ADDR     32'h00000010
`define WDT_CFG_LONG_BIT   0
`define WDT_EVT_RESET_BIT  0
`define WDT_EVT_SERV_BIT   1
`define WDT_EVT_WIDTH      2
`define WDT_CONFIG_RESET   1'b0
`define WDT_ENABLE_RESET   2'h0
`define WDT_CLK_PERIOD_NS  50
`define WDT_LONG_CYCLES    262128
`define WDT_SHORT_CYCLES   8176
`define WDT_PULSE_CYCLES   32
`define WDT_POR_CYCLES     4096
`define WDT_SERV_CLR_LSB   4
`endif

/* File: rtl/wdt_pkg.sv */
// Types shared by the watchdog unit.
package wdt_pkg;
  // Captured AHB address phase.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } wdt_aphase_t;

  // Mode levels that decide whether the watchdog may run.
  typedef struct packed {
    logic monitor;
    logic brk;
    logic stop;
    logic disable_cfg;
  } wdt_mode_t;

  // Register selected by an access.
  typedef enum {
    WDT_SEL_NONE,
    WDT_SEL_SERVICE,
    WDT_SEL_CONFIG,
    WDT_SEL_CAUSE,
    WDT_SEL_CLEAR,
    WDT_SEL_ENABLE,
    WDT_SEL_COUNT
  } wdt_sel_t;
endpackage

/* File: rtl/wdt_top.sv */
// Watchdog unit with AHB-Lite register access and open-drain reset pin drive.
`timescale 1ns/10ps
`include "wdt_map.svh"

module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned PRESC_W      = 12,
  parameter int unsigned CNT_W        = 6,
  parameter int unsigned LONG_CYCLES  = `WDT_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = `WDT_SHORT_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hsel,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [7:0]  i_reset_vector_low,
  input  wire logic        i_reset_vector_fetch,
  input  wire logic        i_internal_reset,
  input  wire logic        i_stop_instr,
  input  wire logic        i_stop_mode,
  input  wire logic        i_wait_mode,
  input  wire logic        i_monitor_mode,
  input  wire logic        i_break_state,
  input  wire logic        i_watchdog_disable,
  input  wire logic        i_irq_pin_high_test_voltage,
  input  wire logic        i_rst_pin_high_test_voltage,
  input  wire logic        i_rst_pin_in,
  output logic             o_rst_pin_out,
  output logic             o_rst_pin_oe,
  output logic             o_irq
);

  // Width of the whole chain and the last elapsed value before each limit.
  localparam int unsigned TOT_W = PRESC_W + CNT_W;
  localparam int unsigned NPIN  = 2;
  localparam logic [TOT_W-1:0] LONG_LAST  = TOT_W'(LONG_CYCLES - 1);
  localparam logic [TOT_W-1:0] SHORT_LAST = TOT_W'(SHORT_CYCLES - 1);

  // Pulse and power-up counts, sized to their registers.
  localparam logic [5:0] PULSE_LEN = 6'(`WDT_PULSE_CYCLES);
  localparam logic [12:0] POR_LEN  = 13'(`WDT_POR_CYCLES);

  // Pin synchroniser stages and the filtered levels.
  logic [NPIN-1:0]             pin_raw;
  logic [NPIN-1:0]             sync1_reg;
  logic [NPIN-1:0]             sync2_reg;
  logic [NPIN-1:0]             sync3_reg;
  logic [NPIN-1:0]             pin_reg;

  // Mode levels and the combined hold.
  wdt_mode_t                   mode;
  logic                        irq_hv;
  logic                        rst_hv;
  logic                        halted;

  // Bus capture, decoded writes and software registers.
  wdt_aphase_t                 aph_reg;
  wdt_sel_t                    wr_sel;
  logic                        wr_fire;
  logic                        service;
  logic                        long_sel_reg;
  logic [`WDT_EVT_WIDTH-1:0]   cause_reg;
  logic [`WDT_EVT_WIDTH-1:0]   cause_next;
  logic [`WDT_EVT_WIDTH-1:0]   enable_reg;
  logic [`WDT_EVT_WIDTH-1:0]   event_set;
  logic [`WDT_EVT_WIDTH-1:0]   event_clr;

  // Timer chain and its limit compare.
  logic [PRESC_W-1:0]          presc_reg;
  logic [CNT_W-1:0]            cnt_reg;
  logic [TOT_W-1:0]            elapsed;
  logic                        overflow;

  // Reset pulse, power-up delay and the clear terms.
  logic [5:0]                  pulse_reg;
  logic                        pulsing;
  logic [12:0]                 por_reg;
  logic                        por_clear;
  logic                        presc_clear;
  logic                        all_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the read and write paths.
  ////////////////////////////////////////////////////////////////////////////

  // Maps a byte address to the register it selects.
  // The service location decodes on its full byte address, four times its index.
  function automatic wdt_sel_t wdt_decode(input logic [31:0] addr);
    wdt_sel_t sel;
    sel = WDT_SEL_NONE;
    case (addr)
      `WDT_SERVICE_ADDR: sel = WDT_SEL_SERVICE;
      `WDT_CONFIG_ADDR:  sel = WDT_SEL_CONFIG;
      `WDT_CAUSE_ADDR:   sel = WDT_SEL_CAUSE;
      `WDT_CLEAR_ADDR:   sel = WDT_SEL_CLEAR;
      `WDT_ENABLE_ADDR:  sel = WDT_SEL_ENABLE;
      `WDT_COUNT_ADDR:   sel = WDT_SEL_COUNT;
      default:           sel = WDT_SEL_NONE;
    endcase
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs: three flip-flops, a change counts once stages two and three agree.
  ////////////////////////////////////////////////////////////////////////////

  // Pins are packed so that one loop serves both.
  assign pin_raw = {i_rst_pin_high_test_voltage, i_irq_pin_high_test_voltage};

  // The first stage feeds only the second; the filter looks at stages two and three.
  // A one-cycle glitch that reaches stage two never matches stage three, so it is ignored.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          sync3_reg[g] <= 1'b0;
          pin_reg[g]   <= 1'b0;
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            pin_reg[g] <= sync3_reg[g];
          end
        end
      end
    end
  endgenerate

  // Bit 0 is the interrupt pin and bit 1 the reset pin; high while the test voltage is there.
  assign irq_hv = pin_reg[0];
  assign rst_hv = pin_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode.
  ////////////////////////////////////////////////////////////////////////////

  // Mode levels come from logic on the same clock, so they need no synchroniser.
  assign mode.monitor     = i_monitor_mode;
  assign mode.brk         = i_break_state;
  assign mode.stop        = i_stop_mode;
  assign mode.disable_cfg = i_watchdog_disable;

  // Wait mode takes no part here, so the unit keeps counting while waiting.
  // A test voltage counts only while its mode is active; in user mode it does nothing.
  assign halted = mode.disable_cfg
                | (mode.monitor & (irq_hv | rst_hv))
                | (mode.brk & rst_hv);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY.
  ////////////////////////////////////////////////////////////////////////////

  // Captures a NONSEQ or SEQ address phase while the bus is ready.
  // IDLE and BUSY phases leave valid low, so their data phase writes nothing.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aph_reg <= '0;
    end else if (i_hready) begin
      aph_reg.valid <= i_hsel & i_htrans[1];
      aph_reg.write <= i_hwrite;
      aph_reg.addr  <= i_haddr;
    end
  end

  // Write data arrive in the data phase that follows the captured address.
  assign wr_sel  = wdt_decode(aph_reg.addr);
  assign wr_fire = aph_reg.valid & aph_reg.write;
  assign service = wr_fire & (wr_sel == WDT_SEL_SERVICE);

  // The slave never stretches a transfer and never flags an error.
  // Both are registers so that every port of the unit comes from a flip-flop.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // Read data are fetched at the address phase so they stand in the data phase.
  // Unmapped and write-only locations read as zero.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hrdata <= '0;
    end else if (i_hready) begin
      o_hrdata <= '0;
      if (i_hsel && i_htrans[1] && !i_hwrite) begin
        case (wdt_decode(i_haddr))
          WDT_SEL_SERVICE: o_hrdata <= {24'h000000, i_reset_vector_low};
          WDT_SEL_CONFIG:  o_hrdata <= {31'h00000000, long_sel_reg};
          WDT_SEL_CAUSE:   o_hrdata <= {30'h00000000, cause_reg};
          WDT_SEL_ENABLE:  o_hrdata <= {30'h00000000, enable_reg};
          WDT_SEL_COUNT:   o_hrdata <= {14'h0000, elapsed};
          default:         o_hrdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.
  ////////////////////////////////////////////////////////////////////////////

  // Timeout select; zero after reset gives the long period.
  // Going short after the count has passed the short limit delays the reset until a wrap.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      long_sel_reg <= `WDT_CONFIG_RESET;
    end else if (wr_fire && wr_sel == WDT_SEL_CONFIG) begin
      long_sel_reg <= i_hwdata[`WDT_CFG_LONG_BIT];
    end
  end

  // Event enable mask for the status interrupt line.
  // Only the low event bits are stored; upper write data are dropped.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_reg <= `WDT_ENABLE_RESET;
    end else if (wr_fire && wr_sel == WDT_SEL_ENABLE) begin
      enable_reg <= i_hwdata[`WDT_EVT_WIDTH-1:0];
    end
  end

  // Events of this cycle and the write-one-to-clear request.
  // The service event shows software that its service write reached the unit.
  assign event_set[`WDT_EVT_RESET_BIT] = overflow;
  assign event_set[`WDT_EVT_SERV_BIT]  = service;
  assign event_clr = (wr_fire && wr_sel == WDT_SEL_CLEAR) ? i_hwdata[`WDT_EVT_WIDTH-1:0] : '0;

  // A new event in the cycle of its clear keeps the flag set.
  // Software that clears a flag just as the event repeats must not lose it.
  assign cause_next = (cause_reg & ~event_clr) | event_set;

  // Sticky reset-cause flags; they survive the reset pulse they report.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Status line for a system controller, not a processor interrupt request.
  // It uses the next flag value so that it follows a set or clear with no extra cycle.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(cause_next & enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up delay that ends in one prescaler clear.
  ////////////////////////////////////////////////////////////////////////////

  // Counts crystal cycles after power-up and clears the prescaler once at the end.
  // The count stops at its end, so the clear fires once per release of reset.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_reg   <= '0;
      por_clear <= 1'b0;
    end else begin
      por_clear <= 1'b0;
      if (por_reg != POR_LEN) begin
        por_reg <= por_reg + 13'h0001;
        if (por_reg == POR_LEN - 13'h0001) begin
          por_clear <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter.
  ////////////////////////////////////////////////////////////////////////////

  // Whole-chain clear: internal reset, own reset pulse, or a disabled watchdog.
  // Holding the chain clear while disabled gives a full period once the hold lifts.
  assign all_clear = i_internal_reset | pulsing | halted;

  // Clears of the prescaler alone.
  // They leave the counter alone, so a nonzero counter still brings the overflow sooner.
  assign presc_clear = i_stop_instr
                     | mode.stop
                     | i_reset_vector_fetch
                     | por_clear;

  // Prescaler on the crystal clock; a service clears only its upper stages.
  // A clear outranks a service in the same cycle, so no low stage survives a clear.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_reg <= '0;
    end else if (all_clear || presc_clear) begin
      presc_reg <= '0;
    end else if (service) begin
      presc_reg <= {{(PRESC_W-`WDT_SERV_CLR_LSB){1'b0}}, presc_reg[`WDT_SERV_CLR_LSB-1:0]};
    end else begin
      presc_reg <= presc_reg + PRESC_W'(1);
    end
  end

  // Counter steps when the prescaler wraps; stop mode freezes it.
  // It never steps in a cycle in which the prescaler is being cleared.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
    end else if (all_clear || service) begin
      cnt_reg <= '0;
    end else if (!mode.stop && !presc_clear && (&presc_reg)) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Cycles since the last clear, counter above prescaler.
  // Software reads it through the count register to see how far the period has run.
  assign elapsed = {cnt_reg, presc_reg};

  // Overflow at the selected limit while the chain is free to run.
  // A clear or a service in the cycle of the limit wins, and no pulse starts.
  assign overflow = !all_clear && !presc_clear && !service
                  && (elapsed == (long_sel_reg ? SHORT_LAST : LONG_LAST));

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin drive.
  ////////////////////////////////////////////////////////////////////////////

  // Remaining cycles of the low pulse on the reset pin.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_reg <= '0;
    end else if (overflow) begin
      pulse_reg <= PULSE_LEN;
    end else if (pulse_reg != 6'h00) begin
      pulse_reg <= pulse_reg - 6'h01;
    end
  end

  // The chain is held clear for the whole pulse, so timing restarts as the pin is released.
  assign pulsing = (pulse_reg != 6'h00);

  // Open-drain drive: the pin is pulled low for exactly the pulse length.
  // The pulse count loads at the edge at which the enable rises, hence the compare above one.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe  <= 1'b0;
    end else begin
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe  <= overflow | (pulse_reg > 6'h01);
    end
  end

  // Unused observations kept visible to nothing else.
  // These inputs belong to the system port list but play no part in counting.
  logic unused_ok;
  assign unused_ok = ^{i_wait_mode, i_rst_pin_in, i_hsize, i_hwdata[31:`WDT_EVT_WIDTH]};

endmodule

/* File: dv/wdt_top_asserts.sv */
// Concurrent checks on the ports of the watchdog unit.
`timescale 1ns/10ps
`include "wdt_map.svh"
module wdt_top_asserts #(
  parameter int unsigned LONG_CYCLES  = 200,
  parameter int unsigned SHORT_CYCLES = 40
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hsel,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [7:0]  i_reset_vector_low,
  input wire logic        i_reset_vector_fetch,
  input wire logic        i_internal_reset,
  input wire logic        i_stop_instr,
  input wire logic        i_stop_mode,
  input wire logic        i_monitor_mode,
  input wire logic        i_break_state,
  input wire logic        i_watchdog_disable,
  input wire logic        i_irq_pin_high_test_voltage,
  input wire logic        i_rst_pin_high_test_voltage,
  input wire logic        o_rst_pin_out,
  input wire logic        o_rst_pin_oe
);
  ////////////////////////////////////////
  // Accepted address phases and the levels that clear the prescaler or hold it clear.
  logic        acc;
  logic        svc;
  logic        hold;
  int unsigned oe_len;
  int unsigned lo_cnt;
  int unsigned hi_cnt;
  int unsigned q_len;
  assign acc  = i_hsel && i_htrans[1];
  assign svc  = acc && i_hwrite && (i_haddr == `WDT_SERVICE_ADDR);
  assign hold = i_watchdog_disable || i_stop_mode || i_internal_reset || i_reset_vector_fetch || i_stop_instr ||
                (i_monitor_mode && (i_irq_pin_high_test_voltage || i_rst_pin_high_test_voltage)) ||
                (i_break_state && i_rst_pin_high_test_voltage);
  // Pulse length, cycles since the last restart and length of a hold.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oe_len <= 0;
      lo_cnt <= 0;
      hi_cnt <= 0;
      q_len  <= 0;
    end else begin
      oe_len <= o_rst_pin_oe ? oe_len + 1 : 0;
      lo_cnt <= (svc || o_rst_pin_oe) ? 0 : lo_cnt + 1;
      hi_cnt <= (svc || o_rst_pin_oe || hold) ? 0 : hi_cnt + 1;
      q_len  <= hold ? q_len + 1 : 0;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  // A read address phase at one place.
  sequence rd_at(logic [31:0] a);
    acc && !i_hwrite && (i_haddr == a);
  endsequence
  a_serv_read: assert property (rd_at(`WDT_SERVICE_ADDR) |=> o_hrdata == {24'h0, $past(i_reset_vector_low)})
    else $error("service read data wrong");
  a_unmapped_zero: assert property (rd_at(32'h20) |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  a_pin_low: assert property (o_rst_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_pulse_len: assert property ($fell(o_rst_pin_oe) |-> oe_len == 32)
    else $error("reset pulse not 32 cycles");
  a_pulse_max: assert property (oe_len <= 32)
    else $error("reset pulse too long");
  a_timeout_min: assert property ($rose(o_rst_pin_oe) |-> lo_cnt >= SHORT_CYCLES - 18)
    else $error("overflow too soon after service");
  a_timeout_max: assert property (hi_cnt <= 2 * LONG_CYCLES + 8)
    else $error("overflow overdue");
  a_hold_quiet: assert property (q_len > 40 |-> !o_rst_pin_oe)
    else $error("reset while watchdog held");
endmodule

/* File: dv/watchdog_timeout_reset_tb_top.sv */
// Self-checking testbench for the watchdog unit.
`timescale 1ns/10ps
`include "wdt_map.svh"
module watchdog_timeout_reset_tb_top;
  localparam int unsigned LONG_CYCLES  = 200;
  localparam int unsigned SHORT_CYCLES = 40;
  logic        i_core_clk = 1'b0, i_rst_b = 1'b0, i_hwrite = 1'b0, i_wait_mode = 1'b0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, r, t, seed = 32'h00011515;
  logic [1:0]  i_htrans = 2'h0;
  logic [7:0]  i_reset_vector_low = 8'h0;
  logic        i_reset_vector_fetch = 1'b0, i_internal_reset = 1'b0, i_stop_instr = 1'b0, i_stop_mode = 1'b0;
  logic        i_monitor_mode = 1'b0, i_break_state = 1'b0, i_watchdog_disable = 1'b0;
  logic        i_irq_pin_high_test_voltage = 1'b0, i_rst_pin_high_test_voltage = 1'b0;
  logic        o_hreadyout, o_hresp, o_rst_pin_out, o_rst_pin_oe, o_irq;
  int          miscompares = 0, num_checks = 0, cyc = 0, n, p;
  int          pk[3] = '{6, 7, 2};
  wdt_top #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_wdt_top (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hsel(1'b1), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_reset_vector_low(i_reset_vector_low), .i_reset_vector_fetch(i_reset_vector_fetch),
    .i_internal_reset(i_internal_reset), .i_stop_instr(i_stop_instr), .i_stop_mode(i_stop_mode),
    .i_wait_mode(i_wait_mode), .i_monitor_mode(i_monitor_mode), .i_break_state(i_break_state),
    .i_watchdog_disable(i_watchdog_disable), .i_irq_pin_high_test_voltage(i_irq_pin_high_test_voltage),
    .i_rst_pin_high_test_voltage(i_rst_pin_high_test_voltage), .i_rst_pin_in(1'b1),
    .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe), .o_irq(o_irq)
  );
  ////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short.
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Random source for data, vector and service spacing.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare and report.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One single AHB transfer; read data lands in r.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_haddr  <= a;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic serve();
    bus(1'b1, `WDT_SERVICE_ADDR, xs());
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge i_core_clk);
    chk({31'h0, o_irq}, {31'h0, e});
  endtask
  // The reset pin must stay released for k cycles.
  task automatic quiet(input int k);
    n = 0;
    repeat (k) begin
      @(negedge i_core_clk);
      if (o_rst_pin_oe !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
  endtask
  // Wait for a reset pulse, then check its arrival window and its width.
  task automatic meas(input int lo, input int hi);
    n = 0;
    p = 0;
    while (o_rst_pin_oe !== 1'b1 && n < 1000) begin
      @(negedge i_core_clk);
      n++;
    end
    while (o_rst_pin_oe === 1'b1 && p < 100) begin
      @(negedge i_core_clk);
      p++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    chk(32'(p), 32'h20);
  endtask
  // Drive one holding condition or clearing pulse; all others stay low.
  task automatic setc(input int k, input logic v);
    @(posedge i_core_clk);
    i_watchdog_disable          <= (k == 0) && v;
    i_stop_mode                 <= (k == 1) && v;
    i_internal_reset            <= (k == 2) && v;
    i_monitor_mode              <= (k == 3 || k == 4) && v;
    i_irq_pin_high_test_voltage <= (k == 3) && v;
    i_rst_pin_high_test_voltage <= (k == 4 || k == 5) && v;
    i_break_state               <= (k == 5) && v;
    i_reset_vector_fetch        <= (k == 6) && v;
    i_stop_instr                <= (k == 7) && v;
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t = xs();
    i_reset_vector_low <= t[7:0];
    rd(`WDT_CAUSE_ADDR, 32'h0);
    rd(`WDT_ENABLE_ADDR, 32'h0);
    bus(1'b1, 32'h20, xs());
    rd(32'h20, 32'h0);
    rd(`WDT_CONFIG_ADDR, 32'h0);
    rd(`WDT_SERVICE_ADDR, {24'h0, t[7:0]});
    i_wait_mode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      serve();
      quiet(100 + int'(xs() % 32'h3c));
    end
    serve();
    meas(LONG_CYCLES - 18, LONG_CYCLES + 2);
    rd(`WDT_COUNT_ADDR, 32'h1);
    rd(`WDT_CAUSE_ADDR, 32'h3);
    irq_is(1'b0);
    bus(1'b1, `WDT_ENABLE_ADDR, 32'h1);
    irq_is(1'b1);
    bus(1'b1, `WDT_CLEAR_ADDR, 32'h1);
    irq_is(1'b0);
    bus(1'b1, `WDT_ENABLE_ADDR, 32'h2);
    irq_is(1'b1);
    bus(1'b1, `WDT_CLEAR_ADDR, 32'h3);
    rd(`WDT_CAUSE_ADDR, 32'h0);
    irq_is(1'b0);
    serve();
    bus(1'b1, `WDT_CONFIG_ADDR, 32'h1);
    i_wait_mode <= 1'b0;
    rd(`WDT_CONFIG_ADDR, 32'h1);
    serve();
    meas(SHORT_CYCLES - 18, SHORT_CYCLES + 2);
    for (int k = 0; k < 6; k++) begin
      serve();
      setc(k, 1'b1);
      quiet(150);
      setc(k, 1'b0);
      meas(SHORT_CYCLES - 18, SHORT_CYCLES + 8);
    end
    for (int k = 0; k < 3; k++) begin
      serve();
      repeat (12) @(posedge i_core_clk);
      setc(pk[k], 1'b1);
      setc(pk[k], 1'b0);
      meas(SHORT_CYCLES - 3, SHORT_CYCLES + 3);
    end
    // The one-shot power-up clear lands 4096 cycles after release and stretches this timeout.
    setc(0, 1'b1);
    while (cyc < 4078) @(posedge i_core_clk);
    setc(0, 1'b0);
    serve();
    meas(SHORT_CYCLES + 10, SHORT_CYCLES + 30);
    give_verdict();
  end
endmodule

bind wdt_top wdt_top_asserts #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_wdt_top_asserts (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hsel(i_hsel), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_reset_vector_low(i_reset_vector_low), .i_reset_vector_fetch(i_reset_vector_fetch),
  .i_internal_reset(i_internal_reset), .i_stop_instr(i_stop_instr), .i_stop_mode(i_stop_mode),
  .i_monitor_mode(i_monitor_mode), .i_break_state(i_break_state), .i_watchdog_disable(i_watchdog_disable),
  .i_irq_pin_high_test_voltage(i_irq_pin_high_test_voltage),
  .i_rst_pin_high_test_voltage(i_rst_pin_high_test_voltage),
  .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe)
);
